// file: hw/tpc_pkg.sv
// Function
// - Init state: matching select-and-silence enters quiet.
// - Answer select-and-silence with SOF and ack 01.
// - Page reads and writes only when selected.
// - Page read returns SOF, 32 bits, CRC.
// - Block read sends addressed page to block end.
// - Multi-byte fields travel low byte first.
// - Good page write command gets ack 01.
// - Program page, then SOF and ack 01.
// - Good block write command gets ack 01.
// - Each block page programmed then acknowledged.
// - Selected silence command: ack, then quiet.
// - Quiet ignores everything until field loss.
// - Only one selected; selected data unencrypted.
package tpc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          T_WRESP_NS    = 1000;
  localparam int          T_PROG_NS     = 20000;
  localparam logic [11:0] WRESP_CNT     = 12'((T_WRESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PROG_CNT      = 12'((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Frame layout and codes
  // ****************************************************************
  localparam logic [4:0] SELQ_CODE       = 5'h00;
  localparam logic [3:0] CMD_READ_PAGE   = 4'hc;
  localparam logic [3:0] CMD_READ_BLOCK  = 4'hd;
  localparam logic [3:0] CMD_WRITE_PAGE  = 4'h8;
  localparam logic [3:0] CMD_WRITE_BLOCK = 4'h9;
  localparam logic [3:0] CMD_QUIET       = 4'h7;
  localparam logic [1:0] ACK_CODE        = 2'h1;
  localparam logic [5:0] LEN_SELQ        = 6'h2d;
  localparam logic [5:0] LEN_CMD         = 6'h14;
  localparam logic [5:0] LEN_WDATA       = 6'h28;
  localparam logic [5:0] LEN_MAX         = 6'h3f;
  localparam logic [5:0] BITS_PAGE       = 6'h20;
  localparam logic [5:0] BITS_ACK        = 6'h02;
  localparam logic [5:0] BITS_CRC        = 6'h08;
  localparam int         SELQ_LSB        = 40;
  localparam int         WORD_LSB        = 8;
  localparam int         CMD_LSB         = 16;
  localparam int         PAGE_ADDRESS_LSB = 8;
  localparam logic [7:0] CRC_INIT        = 8'hff;
  localparam logic [7:0] CRC_POLY        = 8'h1d;

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [3:0] {
    MD_READY = 4'h1,
    MD_INIT  = 4'h2,
    MD_SEL   = 4'h4,
    MD_QUIET = 4'h8
  } tpc_mode_t;

  typedef enum logic [3:0] {
    PH_RX   = 4'h1,
    PH_WAIT = 4'h2,
    PH_PROG = 4'h4,
    PH_TX   = 4'h8
  } tpc_phase_t;

  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[7] ^ b;
    return {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  // Air order is low byte first, each byte MSB first.
  function automatic logic [31:0] bswap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

endpackage

// file: hw/tpc_page_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_page_cmd
  import tpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rx_valid,
  input  wire logic        rx_bit,
  input  wire logic        rx_eof,
  input  wire logic [31:0] uid,
  input  wire logic        init_enter,
  input  wire logic        select_done,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic             tx_bit,
  output logic             tx_sof,
  output logic             tx_last,
  output logic             selected,
  output logic             quiet,
  output logic             prog_busy
);

  // ****************************************************************
  // State
  // ****************************************************************
  tpc_mode_t   mode_q;
  tpc_phase_t  phase_q;
  logic [44:0] rx_sh_q;
  logic [5:0]  rx_len_q;
  logic [7:0]  rx_crc_q;
  logic [11:0] timer_q;
  logic [5:0]  addr_q;
  logic [1:0]  pages_q;
  logic        wexp_q;
  logic        post_quiet_q;
  logic        resp_data_q;
  logic [31:0] wdata_q;
  logic [31:0] tx_sh_q;
  logic [5:0]  bits_q;
  logic        in_crc_q;
  logic        first_q;
  logic [7:0]  tx_crc_q;
  logic [31:0] mem_q [64];

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  wire         rx_on      = phase_q == PH_RX;
  wire  [3:0]  cmd_w      = rx_sh_q[CMD_LSB +: 4];
  wire  [7:0]  page_address_w = rx_sh_q[PAGE_ADDRESS_LSB +: 8];
  wire  [4:0]  code_w     = rx_sh_q[SELQ_LSB +: 5];
  wire  [31:0] word_w     = bswap(rx_sh_q[WORD_LSB +: 32]);
  // A frame whose CRC residue is not zero is dropped without a word.
  wire         frame_good = rx_eof && rx_on && rx_crc_q == 8'h00;
  wire         hit_selq   = frame_good && mode_q == MD_INIT && rx_len_q == LEN_SELQ
                            && code_w == SELQ_CODE && word_w == uid;
  wire         sel_cmd    = frame_good && mode_q == MD_SEL && !wexp_q
                            && rx_len_q == LEN_CMD;
  wire         hit_rdp    = sel_cmd && cmd_w == CMD_READ_PAGE;
  wire         hit_rdb    = sel_cmd && cmd_w == CMD_READ_BLOCK;
  wire         hit_wrp    = sel_cmd && cmd_w == CMD_WRITE_PAGE;
  wire         hit_wrb    = sel_cmd && cmd_w == CMD_WRITE_BLOCK;
  wire         hit_qt     = sel_cmd && cmd_w == CMD_QUIET;
  wire         hit_wdat   = frame_good && mode_q == MD_SEL && wexp_q
                            && rx_len_q == LEN_WDATA;
  // Pages left in the block after the addressed one.
  wire  [1:0]  rest_w     = ~page_address_w[1:0];
  // Only the low six address bits reach the array.
  wire  [5:0]  page_w     = page_address_w[5:0];

  // ****************************************************************
  // Transmit decode
  // ****************************************************************
  wire         tx_fire    = phase_q == PH_TX && tx_ready;
  wire         seg_end    = bits_q == 6'h01;
  wire         more_page  = resp_data_q && pages_q != 2'h0;
  wire         crc_next   = resp_data_q && !in_crc_q;
  wire         tx_done    = tx_fire && seg_end && !more_page && !crc_next;
  wire  [7:0]  tx_crc_nx  = crc_step(tx_crc_q, tx_sh_q[31]);
  wire  [5:0]  addr_nx    = 6'(addr_q + 6'h01);
  wire         wait_end   = phase_q == PH_WAIT && timer_q == 12'h000;
  wire         prog_end   = phase_q == PH_PROG && timer_q == 12'h000;
  wire         mem_we     = prog_end;
  wire  [31:0] tx_load    = resp_data_q ? bswap(mem_q[addr_q]) : {ACK_CODE, 30'h0};

  assign tx_valid  = phase_q == PH_TX;
  assign tx_bit    = tx_sh_q[31];
  assign tx_sof    = first_q && phase_q == PH_TX;
  assign tx_last   = phase_q == PH_TX && seg_end && !more_page && !crc_next;
  assign selected  = mode_q == MD_SEL;
  assign quiet     = mode_q == MD_QUIET;
  assign prog_busy = phase_q == PH_PROG;

  // ****************************************************************
  // Receive shifter
  // ****************************************************************
  // Bits that arrive while the tag is answering are dropped.
  always_ff @(posedge clk) begin
    if (rst || rx_eof) begin
      rx_len_q <= 6'h00;
      rx_crc_q <= CRC_INIT;
    end else if (rx_valid && rx_on) begin
      rx_len_q <= (rx_len_q == LEN_MAX) ? LEN_MAX : 6'(rx_len_q + 6'h01);
      rx_crc_q <= crc_step(rx_crc_q, rx_bit);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sh_q <= 45'h0;
    end else if (rx_valid && rx_on) begin
      rx_sh_q <= {rx_sh_q[43:0], rx_bit};
    end
  end

  // ****************************************************************
  // Mode
  // ****************************************************************
  // Loss of field is rst, the only way out of quiet.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MD_READY;
    end else begin
      unique case (mode_q)
        MD_READY: if (init_enter) mode_q <= MD_INIT;
        MD_INIT: begin
          if (tx_done && post_quiet_q) begin
            mode_q <= MD_QUIET;
          end else if (select_done) begin
            mode_q <= MD_SEL;
          end
        end
        MD_SEL: if (tx_done && post_quiet_q) mode_q <= MD_QUIET;
        MD_QUIET: mode_q <= MD_QUIET;
      endcase
    end
  end

  // ****************************************************************
  // Memory
  // ****************************************************************
  // No reset on the array: it stands for non-volatile pages.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[addr_q] <= wdata_q;
    end
  end

  // ****************************************************************
  // Command sequencing
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q      <= PH_RX;
      timer_q      <= 12'h000;
      addr_q       <= 6'h00;
      pages_q      <= 2'h0;
      wexp_q       <= 1'b0;
      post_quiet_q <= 1'b0;
      resp_data_q  <= 1'b0;
      wdata_q      <= 32'h0;
      tx_sh_q      <= 32'h0;
      bits_q       <= 6'h00;
      in_crc_q     <= 1'b0;
      first_q      <= 1'b0;
      tx_crc_q     <= CRC_INIT;
    end else begin
      unique case (phase_q)
        PH_RX: begin
          timer_q <= WRESP_CNT;
          if (hit_selq || hit_qt) begin
            post_quiet_q <= 1'b1;
            resp_data_q  <= 1'b0;
            phase_q      <= PH_WAIT;
          end else if (hit_rdp || hit_rdb) begin
            resp_data_q <= 1'b1;
            addr_q      <= page_w;
            pages_q     <= hit_rdb ? rest_w : 2'h0;
            phase_q     <= PH_WAIT;
          end else if (hit_wrp || hit_wrb) begin
            resp_data_q <= 1'b0;
            addr_q      <= page_w;
            pages_q     <= hit_wrb ? rest_w : 2'h0;
            wexp_q      <= 1'b1;
            phase_q     <= PH_WAIT;
          end else if (hit_wdat) begin
            resp_data_q <= 1'b0;
            wdata_q     <= word_w;
            timer_q     <= PROG_CNT;
            phase_q     <= PH_PROG;
          end
        end
        PH_WAIT, PH_PROG: begin
          if (wait_end || prog_end) begin
            tx_sh_q  <= tx_load;
            bits_q   <= resp_data_q ? BITS_PAGE : BITS_ACK;
            first_q  <= 1'b1;
            in_crc_q <= 1'b0;
            tx_crc_q <= CRC_INIT;
            phase_q  <= PH_TX;
          end else begin
            timer_q <= 12'(timer_q - 12'h001);
          end
          if (prog_end) begin
            addr_q  <= addr_nx;
            pages_q <= 2'(pages_q - 2'h1);
            wexp_q  <= pages_q != 2'h0;
          end
        end
        PH_TX: begin
          if (tx_fire) begin
            first_q <= 1'b0;
            if (!in_crc_q) begin
              tx_crc_q <= tx_crc_nx;
            end
            if (!seg_end) begin
              tx_sh_q <= {tx_sh_q[30:0], 1'b0};
              bits_q  <= 6'(bits_q - 6'h01);
            end else if (more_page) begin
              tx_sh_q <= bswap(mem_q[addr_nx]);
              addr_q  <= addr_nx;
              pages_q <= 2'(pages_q - 2'h1);
              bits_q  <= BITS_PAGE;
            end else if (crc_next) begin
              tx_sh_q  <= {tx_crc_nx, 24'h0};
              in_crc_q <= 1'b1;
              bits_q   <= BITS_CRC;
            end else begin
              phase_q      <= PH_RX;
              post_quiet_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: tb/tpc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_chk
  import tpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_eof,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic tx_bit,
  input wire logic tx_sof,
  input wire logic tx_last,
  input wire logic selected,
  input wire logic quiet,
  input wire logic prog_busy
);
  // ************************************************************
  // Answer framing and state checks
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] pcnt_q;
  // A counter is used because the programming wait is far beyond any repetition bound.
  always_ff @(posedge clk) begin
    if (rst || !prog_busy)
      pcnt_q <= 12'h000;
    else
      pcnt_q <= pcnt_q + 12'h001;
  end
  sequence s_enter_quiet;
    !quiet ##1 quiet;
  endsequence
  a_sof_first: assert property ($rose(tx_valid) |-> tx_sof)
    else $error("answer started without frame start");
  a_sof_once: assert property (tx_valid && tx_ready |=> !tx_sof)
    else $error("frame start repeated");
  a_bit_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit))
    else $error("answer bit lost while stalled");
  a_resp_wait: assert property (rx_eof |=> !tx_valid [*8])
    else $error("answer before response wait");
  a_quiet_silent: assert property (quiet |-> !tx_valid && !prog_busy)
    else $error("quiet device answered");
  a_quiet_sticky: assert property (quiet |=> quiet)
    else $error("quiet left without field loss");
  a_quiet_entry: assert property (s_enter_quiet |-> $past(tx_valid && tx_ready && tx_last))
    else $error("quiet entered without acknowledge");
  a_one_state: assert property (!(selected && quiet))
    else $error("selected and quiet together");
  a_prog_gate: assert property (prog_busy |-> selected && !tx_valid)
    else $error("programming outside selected state");
  a_prog_len: assert property ($fell(prog_busy) |-> pcnt_q >= PROG_CNT - 12'h004 && pcnt_q <= PROG_CNT + 12'h002)
    else $error("programming time wrong");
endmodule
bind tpc_page_cmd tpc_chk chk_u (.clk(clk), .rst(rst), .rx_eof(rx_eof), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_sof(tx_sof), .tx_last(tx_last),
  .selected(selected), .quiet(quiet), .prog_busy(prog_busy));
`default_nettype wire

// file: tb/tpc_reader.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_reader (
  input  wire logic clk,
  input  wire logic hold,
  input  wire logic tx_valid,
  input  wire logic tx_bit,
  input  wire logic tx_sof,
  input  wire logic tx_last,
  output logic      rx_valid,
  output logic      rx_bit,
  output logic      rx_eof,
  output logic      tx_ready
);
  // ************************************************************
  // Reader side of the air link
  // ************************************************************
  logic got_q[$];
  logic sof_ok = 1'b0;
  logic done = 1'b0;
  initial {rx_valid, rx_bit, rx_eof, tx_ready} = 4'h1;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      if (got_q.size() == 0)
        sof_ok = tx_sof;
      got_q.push_back(tx_bit);
      if (tx_last)
        done = 1'b1;
    end
    tx_ready <= !hold;
  end
  // The idle data line shows the inverse of the last bit so a stale value is never mistaken.
  task automatic send(input logic q[$]);
    foreach (q[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_bit <= q[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_bit <= ~rx_bit;
    rx_eof <= 1'b1;
    @(posedge clk);
    rx_eof <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tpc_page_cmd_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_page_cmd_bench;
  import tpc_pkg::*;
  // ************************************************************
  // Stimulus, reference model and checks
  // ************************************************************
  localparam int WSC_CYC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic init_enter = 1'b0;
  logic select_done = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic [31:0] uid = 32'h5a3c7e11;
  logic rx_valid, rx_bit, rx_eof, tx_ready, tx_valid, tx_bit, tx_sof;
  logic tx_last, selected, quiet, prog_busy;
  logic fr_q[$];
  logic exp_q[$];
  logic [31:0] mem [64];
  logic [31:0] rs = 32'h0000000f;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int pb_cyc = 0;
  always #4 clk = ~clk;
  tpc_page_cmd dut_u (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .rx_eof(rx_eof), .uid(uid), .init_enter(init_enter), .select_done(select_done),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_sof(tx_sof),
    .tx_last(tx_last), .selected(selected), .quiet(quiet), .prog_busy(prog_busy));
  tpc_reader rdr_u (.clk(clk), .hold(hold), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_sof(tx_sof), .tx_last(tx_last), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .rx_eof(rx_eof), .tx_ready(tx_ready));
  function automatic logic [31:0] sw(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [7:0] crcq(input logic q[$]);
    logic [7:0] c;
    c = CRC_INIT;
    foreach (q[i]) c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic put(ref logic q[$], input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) q.push_back(v[i]);
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The hang limit sits well above the longest expected run of about 24000 cycles.
  always @(posedge clk) begin
    cyc++;
    void'(xs());
    if (prog_busy === 1'b1) pb_cyc++;
    hold <= slow & rs[0];
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic xfer(input bit ans, input logic [7:0] flip);
    int i;
    put(fr_q, 32'(crcq(fr_q) ^ flip), 8);
    rdr_u.got_q.delete();
    rdr_u.done = 1'b0;
    rdr_u.send(fr_q);
    fr_q.delete();
    for (i = 0; i < 3000 && rdr_u.done !== 1'b1; i++) @(posedge clk);
    if (ans) begin
      chk(rdr_u.sof_ok && rdr_u.got_q.size() == exp_q.size(), "answer frame");
      foreach (exp_q[k]) chk(rdr_u.got_q[k] === exp_q[k], "answer bit");
    end else
      chk(rdr_u.got_q.size() == 0, "unexpected answer");
    exp_q.delete();
    repeat (3) @(posedge clk);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] a, input bit ans, input logic [7:0] f);
    if (ans)
      put(exp_q, 32'h1, 2);
    put(fr_q, {20'h0, c, a}, 12);
    xfer(ans, f);
  endtask
  task automatic selq(input logic [31:0] f, input bit ans);
    if (ans)
      put(exp_q, 32'h1, 2);
    put(fr_q, 32'h0, 5);
    put(fr_q, sw(uid ^ f), 32);
    xfer(ans, 8'h00);
  endtask
  task automatic wdata(input logic [5:0] p);
    int pb0;
    mem[p] = xs();
    put(fr_q, sw(mem[p]), 32);
    put(exp_q, 32'h1, 2);
    repeat (WSC_CYC) @(posedge clk);
    pb0 = pb_cyc;
    xfer(1'b1, 8'h00);
    chk(pb_cyc - pb0 == PROG_CNT + 1, "programming time");
  endtask
  task automatic rd(input logic [3:0] c, input logic [5:0] a);
    logic [5:0] p;
    p = a;
    put(exp_q, sw(mem[p]), 32);
    while (c == CMD_READ_BLOCK && p[1:0] != 2'h3) begin
      p++;
      put(exp_q, sw(mem[p]), 32);
    end
    put(exp_q, 32'(crcq(exp_q)), 8);
    put(fr_q, {20'h0, c, 2'h0, a}, 12);
    xfer(1'b1, 8'h00);
  endtask
  task pulse_init();
    @(posedge clk);
    init_enter <= 1'b1;
    @(posedge clk);
    init_enter <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    pulse_init();
    cmd(CMD_READ_PAGE, 8'h05, 1'b0, 8'h00);
    selq(32'h00000100, 1'b0);
    select_done <= 1'b1;
    @(posedge clk);
    select_done <= 1'b0;
    @(posedge clk);
    chk(selected, "select");
    slow <= 1'b1;
    cmd(CMD_WRITE_PAGE, 8'h05, 1'b1, 8'h00);
    wdata(6'h05);
    cmd(CMD_WRITE_BLOCK, 8'h06, 1'b1, 8'h00);
    wdata(6'h06);
    wdata(6'h07);
    rd(CMD_READ_BLOCK, 6'h05);
    rd(CMD_READ_PAGE, 6'h07);
    cmd(CMD_READ_PAGE, 8'h07, 1'b0, 8'h01);
    cmd(4'h3, 8'h07, 1'b0, 8'h00);
    cmd(CMD_QUIET, 8'h2a, 1'b1, 8'h00);
    chk(quiet && !selected, "silence");
    cmd(CMD_READ_PAGE, 8'h05, 1'b0, 8'h00);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(!quiet && !selected, "field loss");
    pulse_init();
    selq(32'h00000000, 1'b1);
    chk(quiet, "direct quiet");
    summarize();
  end
endmodule
`default_nettype wire
